// ### hw/sdram_pin_pkg.sv
// Constants shared by the SDRAM command pin logic and its sequencer.
// Assumes a single 10 MHz system clock and synchronous active-high reset.
package sdram_pin_pkg;

    // Upper address bits that mark the SDRAM region
    localparam logic [1:0] SDRAM_REGION   = 2'h1;
    localparam int         ADDR_MSB       = 31;
    localparam int         BANK_LSB       = 28;
    localparam int         ADDR_BIT_TEN   = 10;
    localparam int         BANK_COUNT     = 4;

    // Operation codes requested by the external port
    typedef enum logic [2:0] {
        OP_NONE      = 3'h0,
        OP_READ      = 3'h1,
        OP_WRITE     = 3'h2,
        OP_REFRESH   = 3'h3,
        OP_PRECHARGE = 3'h4,
        OP_MODE_SET  = 3'h5
    } sdram_op_t;

    // Row, column and write strobe triples, active low: {ras, cas, we}
    localparam logic [2:0] CMD_NOP       = 3'h7;
    localparam logic [2:0] CMD_ACTIVATE  = 3'h3;
    localparam logic [2:0] CMD_READ      = 3'h5;
    localparam logic [2:0] CMD_WRITE     = 3'h4;
    localparam logic [2:0] CMD_PRECHARGE = 3'h2;
    localparam logic [2:0] CMD_REFRESH   = 3'h1;
    localparam logic [2:0] CMD_MODE_SET  = 3'h0;
    localparam logic [2:0] CMD_SELF_REF  = 3'h1;

    // Sequencer states, one-hot
    typedef enum logic [5:0] {
        ST_IDLE   = 6'h01,
        ST_ROW    = 6'h02,
        ST_COL    = 6'h04,
        ST_SINGLE = 6'h08,
        ST_SLEEP  = 6'h10,
        ST_GRANT  = 6'h20
    } seq_state_t;

endpackage : sdram_pin_pkg

// ### hw/sdram_seq_if.sv
// Carrier between the pin logic and its command sequencer.
// Assumes both sides run on the same system clock.
`timescale 1ns/1ps
`default_nettype none
interface sdram_seq_if;
    import sdram_pin_pkg::*;
    logic       start;     // Take a new operation
    sdram_op_t  op;        // Operation being taken
    logic       sleep;     // Enter self-refresh and hand bus over
    logic       idle;      // Sequencer can take work
    logic       row_slot;  // Row command cycle
    logic       col_slot;  // Column command cycle
    logic       one_slot;  // Single command cycle
    logic       enter_sr;  // Self-refresh entry cycle
    logic       granted;   // Bus released to host
    modport seq (input start, op, sleep,
                 output idle, row_slot, col_slot, one_slot, enter_sr,
                 granted);
    modport pin (output start, op, sleep,
                 input idle, row_slot, col_slot, one_slot, enter_sr,
                 granted);
endinterface : sdram_seq_if
`default_nettype wire

// ### hw/sdram_seq.sv
// Command sequencer: walks row, column, single and self-refresh phases.
// Assumes start is only raised while idle is high.
`timescale 1ns/1ps
`default_nettype none
module sdram_seq
    import sdram_pin_pkg::*;
(
    input  wire logic   clock_in,   // System clock
    input  wire logic   reset_in,   // Synchronous reset
    input  wire logic   host_req_in, // Host asks for bus
    sdram_seq_if.seq    sq          // Toward pin logic
);
    seq_state_t state;       // Current phase
    seq_state_t next_state;  // Following phase

    // Next phase selection
    always_comb begin
        next_state = state;
        unique case (state)
            ST_IDLE: begin
                if (sq.sleep)
                    next_state = ST_SLEEP;
                else if (sq.start && (sq.op == OP_READ
                                   || sq.op == OP_WRITE))
                    next_state = ST_ROW;
                else if (sq.start && sq.op != OP_NONE)
                    next_state = ST_SINGLE;
            end
            ST_ROW:    next_state = ST_COL;
            ST_COL:    next_state = ST_IDLE;
            ST_SINGLE: next_state = ST_IDLE;
            ST_SLEEP:  next_state = ST_GRANT;
            ST_GRANT: begin
                // Hold grant until host lets go
                if (!host_req_in)
                    next_state = ST_IDLE;
            end
            default:   next_state = ST_IDLE;
        endcase
    end

    // Phase register
    always_ff @(posedge clock_in) begin
        if (reset_in)
            state <= ST_IDLE;
        else
            state <= next_state;
    end

    assign sq.idle     = (state == ST_IDLE);
    assign sq.row_slot = (state == ST_ROW);
    assign sq.col_slot = (state == ST_COL);
    assign sq.one_slot = (state == ST_SINGLE);
    assign sq.enter_sr = (state == ST_SLEEP);
    assign sq.granted  = (state == ST_GRANT);

endmodule : sdram_seq
`default_nettype wire

// ### hw/sdram_pin_logic.sv
// SDRAM command pin logic of the external port: bank selects, strobes,
// word masks, dedicated address bit ten, clock gate and host hand-over.
// Assumes one system clock, synchronous reset, requests held for a cycle.
//
// Summary of operation
// - Assert bank select for every SDRAM command.
// - Only bus master drives bank selects.
// - Row strobe low with valid row address.
// - Column strobe low with valid column.
// - Write strobe low write, high read.
// - Other commands encoded on three strobes.
// - Masks meaningful only at column; reads inactive.
// - Odd word on wide bus masks low.
// - Even single word or narrow bus masks high.
// - Address bit ten on dedicated pin.
// - Clock gate low for self-refresh, suspend.
// - Clock gate default high, low if sleeping.
// - Finish, self-refresh, float pins, then grant.
`timescale 1ns/1ps
`default_nettype none
module sdram_pin_logic
    import sdram_pin_pkg::*;
#(
    parameter int ADDR_W = 32      // External address width
)(
    input  wire logic              clock_in,        // System clock
    input  wire logic              reset_in,        // Synchronous reset
    input  wire logic              req_valid_in,    // New request
    input  wire sdram_op_t         req_op_in,       // Requested operation
    input  wire logic [ADDR_W-1:0] req_addr_in,     // Request address
    input  wire logic              req_single_in,   // Single word access
    input  wire logic              req_odd_in,      // Odd word address
    input  wire logic              bus_narrow_in,   // Memory on 32-bit bus
    input  wire logic              bus_master_in,   // We own the bus
    input  wire logic              suspend_in,      // Suspend request
    input  wire logic              host_bus_request_in, // Host wants bus
    output logic                   req_ready_out,   // Request accepted
    output logic [BANK_COUNT-1:0]  sdram_bank_selects_out,   // Low active
    output logic [BANK_COUNT-1:0]  sdram_bank_selects_oe_out,
    output logic                   row_strobe_out,  // Low active
    output logic                   col_strobe_out,  // Low active
    output logic                   sdram_write_strobe_out, // Low active
    output logic                   ctrl_oe_out,     // Strobes driven
    output logic                   low_word_mask_out,
    output logic                   high_word_mask_out,
    output logic                   sdram_addr_bit_ten_out,
    output logic                   sdram_clock_gate_out,
    output logic                   host_bus_grant_out
);
    sdram_seq_if sq ();              // Sequencer carrier
    sdram_op_t   op;                 // Latched operation
    logic [ADDR_W-1:0] addr;         // Latched address
    logic        single;             // Latched single flag
    logic        odd;                // Latched odd flag
    logic        in_region;          // Address hits SDRAM space
    logic        take;               // Request accepted now
    logic        sleep_done;         // Self-refresh reached
    logic [2:0]  next_cmd;           // Next strobe triple
    logic [1:0]  bank;               // Latched bank index

    // Region check on upper two address bits
    assign in_region = (req_addr_in[ADDR_MSB -: 2] == SDRAM_REGION);
    // Accept work only when idle, master and no host pending
    assign take = req_valid_in && sq.idle && bus_master_in
                  && !host_bus_request_in
                  && (in_region || req_op_in == OP_REFRESH);
    assign req_ready_out = take;
    assign sq.start = take;
    assign sq.op    = req_op_in;
    // Host request waits for idle, so outstanding work finishes first
    assign sq.sleep = sq.idle && host_bus_request_in && bus_master_in;

    sdram_seq u_seq (
        .clock_in   (clock_in),
        .reset_in   (reset_in),
        .host_req_in(host_bus_request_in),
        .sq         (sq)
    );

    // Latch request fields
    always_ff @(posedge clock_in) begin
        if (reset_in) begin
            op     <= OP_NONE;
            addr   <= '0;
            single <= 1'b0;
            odd    <= 1'b0;
        end else if (take) begin
            op     <= req_op_in;
            addr   <= req_addr_in;
            single <= req_single_in;
            odd    <= req_odd_in;
        end
    end
    assign bank = addr[BANK_LSB +: 2];

    // Strobe triple for the coming cycle
    always_comb begin
        next_cmd = CMD_NOP;
        if (sq.row_slot)
            next_cmd = CMD_ACTIVATE;
        else if (sq.col_slot)
            next_cmd = (op == OP_WRITE) ? CMD_WRITE : CMD_READ;
        else if (sq.one_slot) begin
            unique case (op)
                OP_REFRESH:   next_cmd = CMD_REFRESH;
                OP_PRECHARGE: next_cmd = CMD_PRECHARGE;
                OP_MODE_SET:  next_cmd = CMD_MODE_SET;
                default:      next_cmd = CMD_NOP;
            endcase
        end else if (sq.enter_sr)
            next_cmd = CMD_SELF_REF;
    end

    // Registered strobes
    always_ff @(posedge clock_in) begin
        if (reset_in) begin
            row_strobe_out         <= 1'b1;
            col_strobe_out         <= 1'b1;
            sdram_write_strobe_out <= 1'b1;
        end else begin
            {row_strobe_out, col_strobe_out, sdram_write_strobe_out}
                <= next_cmd;
        end
    end

    // Bank select, one low per command cycle, all four low for refresh and self-refresh
    always_ff @(posedge clock_in) begin
        if (reset_in)
            sdram_bank_selects_out <= '1;
        else if (next_cmd != CMD_NOP && !sq.enter_sr
                 && (op != OP_REFRESH || sq.row_slot || sq.col_slot))
            sdram_bank_selects_out <= ~(BANK_COUNT'(1) << bank);
        else if (next_cmd != CMD_NOP)
            sdram_bank_selects_out <= '0;   // Refresh all banks together
        else
            sdram_bank_selects_out <= '1;
    end

    // Word masks valid only at column write
    always_ff @(posedge clock_in) begin
        if (reset_in) begin
            low_word_mask_out  <= 1'b0;
            high_word_mask_out <= 1'b0;
        end else if (sq.col_slot && op == OP_WRITE) begin
            low_word_mask_out  <= odd && !bus_narrow_in;
            high_word_mask_out <= (single && !odd)
                                  || bus_narrow_in;
        end else begin
            low_word_mask_out  <= 1'b0;
            high_word_mask_out <= 1'b0;
        end
    end

    // Dedicated address bit ten, independent of shared address bus
    always_ff @(posedge clock_in) begin
        if (reset_in)
            sdram_addr_bit_ten_out <= 1'b0;
        else if (sq.row_slot)
            sdram_addr_bit_ten_out <= addr[ADDR_BIT_TEN];
        else if (sq.one_slot && op == OP_PRECHARGE)
            sdram_addr_bit_ten_out <= 1'b1;
        else
            sdram_addr_bit_ten_out <= 1'b0;
    end

    // Self-refresh memory
    always_ff @(posedge clock_in) begin
        if (reset_in)
            sleep_done <= 1'b0;
        else if (sq.enter_sr)
            sleep_done <= 1'b1;
        else if (sq.idle)
            sleep_done <= 1'b0;
    end

    // Clock gate: low in self-refresh or suspend
    always_ff @(posedge clock_in) begin
        if (reset_in)
            sdram_clock_gate_out <= 1'b1;
        else if (sq.enter_sr || (sq.granted && sleep_done))
            sdram_clock_gate_out <= 1'b0;
        else
            sdram_clock_gate_out <= !(suspend_in && sq.idle);
    end

    // Drive enables and grant, floated pins before grant
    always_ff @(posedge clock_in) begin
        if (reset_in) begin
            ctrl_oe_out        <= 1'b0;
            host_bus_grant_out <= 1'b0;
        end else begin
            ctrl_oe_out        <= bus_master_in && !sq.granted;
            host_bus_grant_out <= sq.granted && !ctrl_oe_out;
        end
    end
    assign sdram_bank_selects_oe_out = {BANK_COUNT{ctrl_oe_out}};

    // Strobes float the cycle after mastership is lost
    property p_master_float;
        @(posedge clock_in) disable iff (reset_in)
        !bus_master_in |=> !ctrl_oe_out;
    endproperty
    a_master_float: assert property (p_master_float)
        else $error("control pins driven by non-master");

    // Bank select enables follow mastership
    property p_master_only;
        @(posedge clock_in) disable iff (reset_in)
        !bus_master_in |=> sdram_bank_selects_oe_out == '0;
    endproperty
    a_master_only: assert property (p_master_only)
        else $error("bank select enable while not master");

    // Read: row command, then column read
    property p_row_then_col;
        @(posedge clock_in) disable iff (reset_in)
        take && req_op_in == OP_READ |=> ##1 !row_strobe_out
            ##1 (!col_strobe_out && sdram_write_strobe_out);
    endproperty
    a_row_then_col: assert property (p_row_then_col)
        else $error("read strobe sequence wrong");

    // Write: column cycle with write strobe and a bank selected
    property p_write_col;
        @(posedge clock_in) disable iff (reset_in)
        take && req_op_in == OP_WRITE |=> ##2 (!col_strobe_out
            && !sdram_write_strobe_out && sdram_bank_selects_out != '1);
    endproperty
    a_write_col: assert property (p_write_col)
        else $error("write column command wrong");

    // Masks stay low outside a write column cycle
    property p_mask_read;
        @(posedge clock_in) disable iff (reset_in)
        col_strobe_out || sdram_write_strobe_out || !row_strobe_out
            |-> !low_word_mask_out && !high_word_mask_out;
    endproperty
    a_mask_read: assert property (p_mask_read)
        else $error("mask active outside write column");

    // Refresh encoded on the three strobes
    property p_refresh_cmd;
        @(posedge clock_in) disable iff (reset_in)
        take && req_op_in == OP_REFRESH |=> ##1
            {row_strobe_out, col_strobe_out, sdram_write_strobe_out}
            == CMD_REFRESH;
    endproperty
    a_refresh_cmd: assert property (p_refresh_cmd)
        else $error("refresh not encoded");

    // Grant only with memory asleep and pins floated
    property p_gate_sleep;
        @(posedge clock_in) disable iff (reset_in)
        host_bus_grant_out |-> !sdram_clock_gate_out && !ctrl_oe_out;
    endproperty
    a_gate_sleep: assert property (p_gate_sleep)
        else $error("grant without self-refresh and float");

    // Grant follows the hand-over within a few cycles
    property p_grant_time;
        @(posedge clock_in) disable iff (reset_in)
        sq.sleep |=> ##[1:3] host_bus_grant_out;
    endproperty
    a_grant_time: assert property (p_grant_time)
        else $error("grant late");

    // Main scenarios reached
    c_read: cover property (@(posedge clock_in)
        take && req_op_in == OP_READ);
    c_write_odd: cover property (@(posedge clock_in) low_word_mask_out);
    c_sleep: cover property (@(posedge clock_in) sq.enter_sr);
    c_grant: cover property (@(posedge clock_in) host_bus_grant_out);
endmodule : sdram_pin_logic
`default_nettype wire

// ### tb/sdram_model.sv
// Behavioural model of the SDRAM devices on the shared memory bus.
// Assumes pins are sampled on the rising system clock edge, as memory does.
`timescale 1ns/1ps
`default_nettype none
module sdram_model
    import sdram_pin_pkg::*;
(
    input  wire logic       clock_in,     // System clock
    input  wire logic [3:0] selects_in,   // Bank selects, low active
    input  wire logic       driven_in,    // Control pins driven
    input  wire logic       ras_in,       // Row strobe
    input  wire logic       cas_in,       // Column strobe
    input  wire logic       we_in,        // Write strobe
    output logic [2:0]      last_cmd_out, // Last decoded command
    output logic [3:0]      last_sel_out, // Selects seen with it
    output logic            cmd_seen_out  // Command taken last edge
);
    // Capture any selected, driven command cycle
    always_ff @(posedge clock_in) begin
        cmd_seen_out <= driven_in && (selects_in !== 4'hF);
        if (driven_in && (selects_in !== 4'hF)) begin
            // Command decoded from the strobe triple
            last_cmd_out <= {ras_in, cas_in, we_in};
            last_sel_out <= selects_in;
        end
    end
endmodule : sdram_model
`default_nettype wire

// ### tb/testbench.sv
// Self-checking bench for the SDRAM command pin logic.
// Assumes a 10 MHz clock and inputs driven at the falling edge.
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import sdram_pin_pkg::*;
    logic        clock_in, reset_in, req_valid, single, odd, narrow;
    logic        master, suspend, host_req, took;
    sdram_op_t   op;
    logic [31:0] addr;
    logic        ready, ras, cas, we, oe, lmask, hmask, bit10, gate, grant;
    logic [3:0]  sel, sel_oe, m_sel;
    logic [2:0]  m_cmd;
    logic        m_seen;
    int          failures, comparisons;

    sdram_pin_logic #(.ADDR_W(32)) i_sdram_pin_logic (
        .clock_in(clock_in), .reset_in(reset_in), .req_valid_in(req_valid),
        .req_op_in(op), .req_addr_in(addr), .req_single_in(single),
        .req_odd_in(odd), .bus_narrow_in(narrow), .bus_master_in(master),
        .suspend_in(suspend), .host_bus_request_in(host_req),
        .req_ready_out(ready), .sdram_bank_selects_out(sel),
        .sdram_bank_selects_oe_out(sel_oe), .row_strobe_out(ras),
        .col_strobe_out(cas), .sdram_write_strobe_out(we), .ctrl_oe_out(oe),
        .low_word_mask_out(lmask), .high_word_mask_out(hmask),
        .sdram_addr_bit_ten_out(bit10), .sdram_clock_gate_out(gate),
        .host_bus_grant_out(grant));

    sdram_model i_sdram_model (
        .clock_in(clock_in), .selects_in(sel), .driven_in(oe),
        .ras_in(ras), .cas_in(cas), .we_in(we), .last_cmd_out(m_cmd),
        .last_sel_out(m_sel), .cmd_seen_out(m_seen));

    // Free-running system clock, 100 ns period
    initial begin
        clock_in = 1'b0;
        forever #50 clock_in = ~clock_in;
    end

    // Single-bit comparison
    task automatic check_bit(input string what, input logic e, input logic g);
        comparisons++;
        if (g !== e) begin
            failures++;
            $display("unexpected %s expected %b seen %b", what, e, g);
        end
    endtask : check_bit

    // Vector comparison for selects and strobe triples
    task automatic check_vec(input string what, input logic [3:0] e,
                             input logic [3:0] g);
        comparisons++;
        if (g !== e) begin
            failures++;
            $display("unexpected %s expected %h seen %h", what, e, g);
        end
    endtask : check_vec

    // Ends the run with the verdict
    task automatic wrap_up;
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : wrap_up

    // Bank select pattern for one bank
    function automatic logic [3:0] one_bank(input logic [1:0] b);
        return ~(4'h1 << b);
    endfunction : one_bank

    // Present a request for one cycle, note whether it was taken
    task automatic issue(input sdram_op_t o, input logic [31:0] a);
        @(negedge clock_in);
        req_valid = 1'b1;
        op = o;
        addr = a;
        #1 took = ready;
        @(negedge clock_in);
        req_valid = 1'b0;
    endtask : issue

    // Full accepted access with pin checks
    task automatic run_access(input sdram_op_t o, input logic [31:0] a);
        logic wr;
        wr = (o == OP_WRITE);
        issue(o, a);
        check_bit("ready", 1'b1, took);
        for (int i = 0; i < 5 && sel === 4'hF; i++) @(negedge clock_in);
        if (o == OP_READ || wr) begin
            check_vec("row cmd", {1'b0, CMD_ACTIVATE},
                      {1'b0, ras, cas, we});
            check_vec("row sel", one_bank(a[29:28]), sel);
            check_bit("row bit ten", a[10], bit10);
            @(negedge clock_in);
            check_vec("col cmd", {1'b0, wr ? CMD_WRITE : CMD_READ},
                      {1'b0, ras, cas, we});
            check_bit("low mask", wr & ~narrow & odd, lmask);
            check_bit("high mask", wr & (narrow | (single & ~odd)),
                      hmask);
            // Memory took the row command at the last edge
            check_bit("model seen", 1'b1, m_seen);
            check_vec("model sel", one_bank(a[29:28]), m_sel);
            @(negedge clock_in);
            check_vec("nop", {1'b0, CMD_NOP}, {1'b0, ras, cas, we});
        end else begin
            check_vec("single cmd", {1'b0, o == OP_REFRESH ? CMD_REFRESH :
                      o == OP_PRECHARGE ? CMD_PRECHARGE : CMD_MODE_SET},
                      {1'b0, ras, cas, we});
            check_bit("bank hit", 1'b0, sel[a[29:28]]);
            if (o == OP_REFRESH) check_vec("refresh sel", 4'h0, sel);
            if (o == OP_PRECHARGE) check_bit("all banks", 1'b1, bit10);
        end
        repeat (2) @(negedge clock_in);
    endtask : run_access

    // Hang guard, well beyond the expected run length
    initial begin
        repeat (20000) @(posedge clock_in);
        failures++;
        wrap_up();
    end

    // Main sequence
    initial begin
        void'($urandom(27));
        {req_valid, single, odd, narrow, suspend, host_req} = '0;
        op = OP_NONE;
        addr = 32'h0;
        master = 1'b1;
        reset_in = 1'b1;
        repeat (3) @(posedge clock_in);
        @(negedge clock_in);
        check_vec("reset cmd", {1'b0, CMD_NOP}, {1'b0, ras, cas, we});
        check_vec("reset sel", 4'hF, sel);
        check_bit("reset gate", 1'b1, gate);
        check_bit("reset grant", 1'b0, grant);
        reset_in = 1'b0;
        repeat (2) @(negedge clock_in);
        check_vec("master oe", 4'hF, sel_oe);
        // Corner cases: bank 3 read with bit ten, odd write on wide bus
        run_access(OP_READ, 32'h7000_0400);
        odd = 1'b1;
        run_access(OP_WRITE, 32'h4000_0000);
        {odd, single, narrow} = 3'b011;
        run_access(OP_WRITE, 32'h5000_0400);
        {odd, single, narrow} = 3'b000;
        for (int k = 3; k <= 5; k++) run_access(sdram_op_t'(k), 32'h6000_0000);
        // Random traffic inside the region
        repeat (40) begin
            {single, odd, narrow} = 3'($urandom);
            run_access(sdram_op_t'($urandom_range(1, 5)),
                       {2'b01, 30'($urandom)});
        end
        // Not master: refused and pins left undriven
        master = 1'b0;
        issue(OP_READ, 32'h4000_0000);
        check_bit("slave ready", 1'b0, took);
        check_vec("slave oe", 4'h0, sel_oe);
        master = 1'b1;
        repeat (3) @(negedge clock_in);
        // Outside the region: no command
        issue(OP_READ, 32'h8000_0000);
        check_bit("outside ready", 1'b0, took);
        repeat (3) @(negedge clock_in);
        check_vec("outside sel", 4'hF, sel);
        // Suspend drops and restores the clock gate
        suspend = 1'b1;
        for (int i = 0; i < 4 && gate !== 1'b0; i++) @(negedge clock_in);
        check_bit("suspend gate", 1'b0, gate);
        suspend = 1'b0;
        for (int i = 0; i < 4 && gate !== 1'b1; i++) @(negedge clock_in);
        check_bit("resume gate", 1'b1, gate);
        // Host hand-over: self-refresh, float, then grant
        host_req = 1'b1;
        for (int i = 0; i < 8 && grant !== 1'b1; i++) @(negedge clock_in);
        check_bit("grant", 1'b1, grant);
        check_vec("sleep cmd", {1'b0, CMD_SELF_REF}, {1'b0, m_cmd});
        check_vec("sleep sel", 4'h0, m_sel);
        check_bit("grant oe", 1'b0, oe);
        check_bit("float seen", 1'b0, m_seen);
        check_bit("grant gate", 1'b0, gate);
        issue(OP_READ, 32'h4000_0000);
        check_bit("host ready", 1'b0, took);
        check_bit("grant held", 1'b1, grant);
        host_req = 1'b0;
        for (int i = 0; i < 8 && grant !== 1'b0; i++) @(negedge clock_in);
        check_bit("grant drop", 1'b0, grant);
        for (int i = 0; i < 8 && gate !== 1'b1; i++) @(negedge clock_in);
        check_bit("wake gate", 1'b1, gate);
        wrap_up();
    end
endmodule : testbench
`default_nettype wire
